// ---- rsf_pkg.sv ----
// package: constants and carrier types of the cpu register set
//==========================================================
// Summary of operation
// - 8-bit accumulator feeds the adder; reset leaves it alone
// - 16-bit index pair, upper byte is high address byte
// - reset forces upper index byte to 0x00, lower kept
// - lower index byte clears, counts, inverts, negates, shifts, rotates
// - 16-bit stack pointer, forced to 0x00FF by reset
// - stack adjust adds sign-extended 8-bit immediate to stack pointer
// - stack low reset touches only the low stack pointer byte
// - calls push return address; interrupts push it plus registers
// - program counter steps on fetch; change-of-flow loads new address
// - after reset program counter loads vector from 0xFFFE/0xFFFF
// - registers have no memory address; memory space is 64 Kbyte
// - flag register bits 6 and 5 always read as 1
// - overflow flag bit 7 on signed overflow; signed branches test it
// - half-carry bit 4 on carry from bit 3 in adds
// - decimal adjust uses half-carry and carry to correct sum
// - mask bit 3 set blocks maskable interrupts, clear allows
// - interrupt sets mask after stacking, before service code
// - no interrupt right after mask clear if mask was set
// - negative bit 2 follows result or moved value msb
// - zero bit 1 set on zero result or moved value
// - carry bit 0 from add carry, borrow, bit test, shifts
package rsf_pkg;

	//==========================================================
	// register offsets on the bus
	localparam logic [7:0] OFS_ACC  = 8'h00;
	localparam logic [7:0] OFS_IDX  = 8'h04;
	localparam logic [7:0] OFS_SP   = 8'h08;
	localparam logic [7:0] OFS_PC   = 8'h0C;
	localparam logic [7:0] OFS_FLG  = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;

	//==========================================================
	// reset values, flag masks and fixed addresses
	localparam logic [15:0] SP_RST   = 16'h00FF;
	localparam logic [7:0]  H_RST    = 8'h00;
	localparam logic [7:0]  FLG_RST  = 8'h68;
	localparam logic [7:0]  FLG_ONES = 8'h60;
	localparam logic [7:0]  FLG_WMSK = 8'h9F;
	localparam logic [15:0] VEC_HI   = 16'hFFFE;
	localparam logic [15:0] VEC_LO   = 16'hFFFF;

	//==========================================================
	// flag bit positions
	localparam int FB_V = 7;
	localparam int FB_H = 4;
	localparam int FB_I = 3;
	localparam int FB_N = 2;
	localparam int FB_Z = 1;
	localparam int FB_C = 0;

	// bytes pushed by call and by interrupt entry
	localparam logic [2:0] CALL_BYTES = 3'd2;
	localparam logic [2:0] INT_BYTES  = 3'd5;

	//==========================================================
	// datapath commands
	typedef enum logic [4:0] {
		OP_NOP, OP_FETCH, OP_JMP, OP_CALL, OP_INT, OP_LDA, OP_STA,
		OP_LDX, OP_LDHX, OP_ADD, OP_ADC, OP_SUB, OP_DEC_ADJ, OP_CLRX,
		OP_INCX, OP_DECX, OP_COMX, OP_NEGX, OP_LSLX, OP_LSRX, OP_ROLX,
		OP_RORX, OP_SP_ADJ, OP_SP_LOW, OP_PUSH, OP_PULL, OP_MASK_CLR,
		OP_SEI, OP_TAP, OP_BTST, OP_BR_LT, OP_BR_GE
	} rsf_opc_t;

	typedef enum logic [2:0] {
		S_VHI, S_VLO, S_VMID, S_VFIN, S_RUN, S_PUSH, S_PULW, S_PULD
	} rsf_sta_t;

	typedef struct packed {
		logic      valid;
		rsf_opc_t  code;
		logic [15:0] data;
	} rsf_op_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} rsf_mem_t;

	typedef struct packed {
		rsf_sta_t    sta;
		logic [7:0]  a;
		logic [7:0]  h;
		logic [7:0]  x;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0]  flg;
		logic        inh;
		logic        isint;
		logic [2:0]  cnt;
		logic [15:0] tgt;
		rsf_mem_t    mem;
		logic        rdy;
		logic        allow;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} rsf_st_t;

endpackage

// ---- rsf_regs.sv ----
// module: cpu register set, flag logic and program counter sequencing
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module rsf_regs
	import rsf_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire rsf_op_t     op,
	output logic             op_ready,
	output logic             int_allow,
	output rsf_mem_t         mem,
	input  wire logic [7:0]  mem_rdata,
	output logic [7:0]       acc,
	output logic [15:0]      index,
	output logic [15:0]      stack_pointer,
	output logic [15:0]      program_counter,
	output logic [7:0]       result_flags
);

	rsf_st_t q, d;

	//==========================================================
	// outputs come straight from the state flops
	assign prdata          = q.prdata;
	assign pready          = q.pready;
	assign pslverr         = q.pslverr;
	assign op_ready        = q.rdy;
	assign int_allow       = q.allow;
	assign mem             = q.mem;
	assign acc             = q.a;
	assign index           = {q.h, q.x};
	assign stack_pointer   = q.sp;
	assign program_counter = q.pc;
	assign result_flags    = q.flg;

	//==========================================================
	// next state
	always_comb begin
		logic        go;
		logic        cin;
		logic        bus_acc;
		logic        bus_wr;
		logic [8:0]  s9;
		logic [4:0]  s5;
		logic [7:0]  r;
		logic [7:0]  cor;
		logic        setnz;
		go      = 1'b0;
		cin     = 1'b0;
		bus_acc = 1'b0;
		bus_wr  = 1'b0;
		s9      = 9'h000;
		s5      = 5'h00;
		r       = 8'h00;
		cor     = 8'h00;
		setnz   = 1'b0;
		d       = q;
		d.mem.rd = 1'b0;
		d.mem.wr = 1'b0;
		go  = op.valid && q.rdy;
		cin = q.flg[FB_C];

		unique case (q.sta)
		// vector fetch: two reads, data one cycle after request
		S_VHI: begin
			d.mem.rd   = 1'b1;
			d.mem.addr = VEC_HI;
			d.sta      = S_VLO;
		end
		S_VLO: begin
			d.mem.rd   = 1'b1;
			d.mem.addr = VEC_LO;
			d.sta      = S_VMID;
		end
		S_VMID: begin
			d.pc[15:8] = mem_rdata;
			d.sta      = S_VFIN;
		end
		S_VFIN: begin
			d.pc[7:0] = mem_rdata;
			d.sta     = S_RUN;
		end
		// push one byte per cycle, pointer drops after the store
		S_PUSH: begin
			d.mem.wr   = 1'b1;
			d.mem.addr = q.sp;
			d.sp       = q.sp - 16'h0001;
			unique case (q.cnt)
			3'd0: d.mem.wdata = q.pc[7:0];
			3'd1: d.mem.wdata = q.pc[15:8];
			3'd2: d.mem.wdata = q.x;
			3'd3: d.mem.wdata = q.a;
			default: d.mem.wdata = q.flg;
			endcase
			d.cnt = q.cnt + 3'd1;
			if ((q.isint && q.cnt == INT_BYTES - 3'd1) ||
			    (!q.isint && q.cnt == CALL_BYTES - 3'd1)) begin
				d.pc  = q.tgt;
				d.sta = S_RUN;
				// mask goes up only once the flags are stacked
				if (q.isint)
					d.flg[FB_I] = 1'b1;
			end
		end
		S_PULW: d.sta = S_PULD;
		S_PULD: begin
			d.a     = mem_rdata;
			r       = mem_rdata;
			setnz   = 1'b1;
			d.sta   = S_RUN;
		end
		S_RUN: begin
			if (go) begin
				// one instruction past a mask clear runs unbroken
				d.inh = 1'b0;
				unique case (op.code)
				OP_NOP: d.inh = q.inh;
				OP_FETCH: d.pc = q.pc + 16'h0001;
				OP_JMP: d.pc = op.data;
				OP_CALL, OP_INT: begin
					d.tgt   = op.data;
					d.isint = (op.code == OP_INT);
					d.cnt   = 3'd0;
					d.sta   = S_PUSH;
				end
				OP_LDA: begin
					d.a = op.data[7:0];
					r = op.data[7:0];
					setnz = 1'b1;
				end
				OP_STA: begin
					d.mem.wr    = 1'b1;
					d.mem.addr  = op.data;
					d.mem.wdata = q.a;
					r = q.a;
					setnz = 1'b1;
				end
				OP_LDX: begin
					d.x = op.data[7:0];
					r = op.data[7:0];
					setnz = 1'b1;
				end
				OP_LDHX: begin
					{d.h, d.x} = op.data;
					d.flg[FB_N] = op.data[15];
					d.flg[FB_Z] = (op.data == 16'h0000);
					d.flg[FB_V] = 1'b0;
				end
				OP_ADD, OP_ADC: begin
					if (op.code == OP_ADD)
						cin = 1'b0;
					s9 = {1'b0, q.a} + {1'b0, op.data[7:0]}
						+ {8'h00, cin};
					s5 = {1'b0, q.a[3:0]} + {1'b0, op.data[3:0]}
						+ {4'h0, cin};
					r = s9[7:0];
					d.a = r;
					d.flg[FB_H] = s5[4];
					d.flg[FB_C] = s9[8];
					d.flg[FB_V] = (q.a[7] == op.data[7]) &&
						(r[7] != q.a[7]);
					setnz = 1'b1;
				end
				OP_SUB: begin
					s9 = {1'b0, q.a} - {1'b0, op.data[7:0]};
					r = s9[7:0];
					d.a = r;
					d.flg[FB_C] = s9[8];
					d.flg[FB_V] = (q.a[7] != op.data[7]) &&
						(r[7] != q.a[7]);
					setnz = 1'b1;
				end
				OP_DEC_ADJ: begin
					// correction chosen from both carries and digits
					if (q.flg[FB_H] || q.a[3:0] > 4'h9)
						cor[3:0] = 4'h6;
					if (q.flg[FB_C] || q.a > 8'h99)
						cor[7:4] = 4'h6;
					r = q.a + cor;
					d.a = r;
					d.flg[FB_C] = (cor[7:4] == 4'h6);
					setnz = 1'b1;
				end
				OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX,
				OP_LSLX, OP_LSRX, OP_ROLX, OP_RORX: begin
					unique case (op.code)
					OP_CLRX: begin
						r = 8'h00;
						d.flg[FB_V] = 1'b0;
					end
					OP_INCX: begin
						r = q.x + 8'h01;
						d.flg[FB_V] = (r == 8'h80);
					end
					OP_DECX: begin
						r = q.x - 8'h01;
						d.flg[FB_V] = (r == 8'h7F);
					end
					OP_COMX: begin
						r = ~q.x;
						d.flg[FB_V] = 1'b0;
						d.flg[FB_C] = 1'b1;
					end
					OP_NEGX: begin
						r = 8'h00 - q.x;
						d.flg[FB_V] = (r == 8'h80);
						d.flg[FB_C] = (r != 8'h00);
					end
					OP_LSLX: begin
						r = {q.x[6:0], 1'b0};
						d.flg[FB_C] = q.x[7];
					end
					OP_LSRX: begin
						r = {1'b0, q.x[7:1]};
						d.flg[FB_C] = q.x[0];
					end
					OP_ROLX: begin
						r = {q.x[6:0], cin};
						d.flg[FB_C] = q.x[7];
					end
					default: begin
						r = {cin, q.x[7:1]};
						d.flg[FB_C] = q.x[0];
					end
					endcase
					// shifts and rotates set overflow to negative xor carry
					if (op.code inside {OP_LSLX, OP_LSRX, OP_ROLX,
					                    OP_RORX})
						d.flg[FB_V] = r[7] ^ d.flg[FB_C];
					d.x = r;
					setnz = 1'b1;
				end
				OP_SP_ADJ: d.sp = q.sp + {{8{op.data[7]}},
					op.data[7:0]};
				OP_SP_LOW: d.sp[7:0] = SP_RST[7:0];
				OP_PUSH: begin
					d.mem.wr    = 1'b1;
					d.mem.addr  = q.sp;
					d.mem.wdata = q.a;
					d.sp        = q.sp - 16'h0001;
				end
				OP_PULL: begin
					d.sp       = q.sp + 16'h0001;
					d.mem.rd   = 1'b1;
					d.mem.addr = q.sp + 16'h0001;
					d.sta      = S_PULW;
				end
				OP_MASK_CLR: begin
					d.flg[FB_I] = 1'b0;
					d.inh = q.flg[FB_I];
				end
				OP_SEI: d.flg[FB_I] = 1'b1;
				OP_TAP: begin
					d.flg = (q.a & FLG_WMSK) | FLG_ONES;
					d.inh = q.flg[FB_I] && !q.a[FB_I];
				end
				OP_BTST: d.flg[FB_C] = q.a[op.data[2:0]];
				OP_BR_LT, OP_BR_GE: begin
					// signed compare reads overflow against sign
					if ((q.flg[FB_N] ^ q.flg[FB_V]) ==
					    (op.code == OP_BR_LT))
						d.pc = q.pc + {{8{op.data[7]}},
							op.data[7:0]};
				end
				default: d.inh = q.inh;
				endcase
			end
		end
		endcase

		// shared negative and zero update for 8-bit results
		if (setnz) begin
			d.flg[FB_N] = r[7];
			d.flg[FB_Z] = (r == 8'h00);
			if (!(q.sta == S_RUN && op.code inside {OP_ADD, OP_ADC,
			    OP_SUB, OP_DEC_ADJ} || q.sta == S_RUN && op.code inside
			    {OP_INCX, OP_DECX, OP_COMX, OP_NEGX, OP_CLRX, OP_LSLX,
			    OP_LSRX, OP_ROLX, OP_RORX}))
				d.flg[FB_V] = 1'b0;
		end

		//==========================================================
		// bus slave: one wait state, write lands with pready
		bus_acc   = psel && penable && !q.pready;
		bus_wr    = psel && penable && q.pready && pwrite;
		d.pready  = bus_acc;
		d.pslverr = 1'b0;
		if (bus_acc) begin
			d.prdata = 32'h0000_0000;
			unique case (paddr)
			OFS_ACC:  d.prdata[7:0]  = q.a;
			OFS_IDX:  d.prdata[15:0] = {q.h, q.x};
			OFS_SP:   d.prdata[15:0] = q.sp;
			OFS_PC:   d.prdata[15:0] = q.pc;
			OFS_FLG:  d.prdata[7:0]  = q.flg | FLG_ONES;
			OFS_STAT: d.prdata[2:0]  = {q.sta != S_RUN, q.inh,
			                            q.allow};
			default:  d.pslverr      = 1'b1;
			endcase
		end
		// software write wins over the datapath in the same cycle
		if (bus_wr) begin
			unique case (paddr)
			OFS_ACC: d.a = pwdata[7:0];
			OFS_IDX: {d.h, d.x} = pwdata[15:0];
			OFS_SP:  d.sp = pwdata[15:0];
			OFS_PC:  d.pc = pwdata[15:0];
			OFS_FLG: d.flg = (pwdata[7:0] & FLG_WMSK)
			                 | FLG_ONES;
			default: d.prdata = q.prdata;
			endcase
		end
		if (!(psel && penable))
			d.prdata = 32'h0000_0000;

		d.flg   = d.flg | FLG_ONES;
		d.rdy   = (d.sta == S_RUN);
		d.allow = !d.flg[FB_I] && !d.inh && d.sta == S_RUN;
	end

	//==========================================================
	// state register; accumulator and low index byte keep their
	// contents through reset, so they have no reset branch entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.sta     <= S_VHI;
			q.h       <= H_RST;
			q.sp      <= SP_RST;
			q.pc      <= 16'h0000;
			q.flg     <= FLG_RST;
			q.inh     <= 1'b0;
			q.isint   <= 1'b0;
			q.cnt     <= 3'd0;
			q.tgt     <= 16'h0000;
			q.mem     <= '0;
			q.rdy     <= 1'b0;
			q.allow   <= 1'b0;
			q.pready  <= 1'b0;
			q.pslverr <= 1'b0;
			q.prdata  <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

endmodule // rsf_regs

// ---- rsf_regs_assertions.sv ----
// checker: port-level properties of the cpu register set
`timescale 1ns/10ps
module rsf_regs_chk
	import rsf_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire rsf_op_t     op,
	input wire logic        op_ready,
	input wire logic        int_allow,
	input wire rsf_mem_t    mem,
	input wire logic [7:0]  mem_rdata,
	input wire logic [7:0]  acc,
	input wire logic [15:0] index,
	input wire logic [15:0] stack_pointer,
	input wire logic [15:0] program_counter,
	input wire logic [7:0]  result_flags
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	//==========================================================
	// sequences
	// an op counts only on an edge where both sides agree
	sequence op_taken(rsf_opc_t c);
		op.valid && op_ready && op.code == c;
	endsequence

	// two vector byte reads on consecutive cycles
	sequence vec_fetch;
		(mem.rd && mem.addr == VEC_HI) ##1 (mem.rd && mem.addr == VEC_LO);
	endsequence

	//==========================================================
	// properties
	fixed_ones_a: assert property (result_flags[6:5] == 2'h3)
		else $error("flag bits 6 and 5 not set");
	reset_values_a: assert property ($rose(presetn) |->
		stack_pointer == SP_RST && index[15:8] == H_RST)
		else $error("reset values wrong");
	vector_load_a: assert property (vec_fetch |-> ##2 (op_ready &&
		program_counter == {$past(mem_rdata, 2), $past(mem_rdata)}))
		else $error("reset vector not loaded");
	// two cycles of mask so a lagging enable is not flagged
	mask_blocks_a: assert property ($past(result_flags[FB_I]) &&
		result_flags[FB_I] |-> !int_allow)
		else $error("interrupt allowed while masked");
	clear_holdoff_a: assert property (op_taken(OP_MASK_CLR) ##0
		result_flags[FB_I] |=> !int_allow)
		else $error("interrupt allowed right after mask clear");
	adjust_sp_a: assert property (op_taken(OP_SP_ADJ) |=>
		stack_pointer == $past(stack_pointer) +
		{{8{$past(op.data[7])}}, $past(op.data[7:0])})
		else $error("stack adjust sum wrong");
	low_reset_a: assert property (op_taken(OP_SP_LOW) |=>
		$stable(stack_pointer[15:8]))
		else $error("stack low reset changed high byte");
	fetch_step_a: assert property (op_taken(OP_FETCH) |=>
		program_counter == $past(program_counter) + 16'h0001)
		else $error("fetch did not step counter");
	pull_order_a: assert property (op_taken(OP_PULL) |=> mem.rd &&
		mem.addr == $past(stack_pointer) + 16'h0001 &&
		stack_pointer == mem.addr)
		else $error("pull did not increment before read");
	push_order_a: assert property (op_taken(OP_PUSH) |=> mem.wr &&
		mem.addr == $past(stack_pointer) &&
		stack_pointer == mem.addr - 16'h0001)
		else $error("push did not store before decrement");
	int_mask_a: assert property (op_taken(OP_INT) |=>
		!result_flags[FB_I] ##[1:7] (op_ready && result_flags[FB_I]))
		else $error("mask set at wrong time on interrupt");
endmodule // rsf_regs_chk

bind rsf_regs rsf_regs_chk u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .op, .op_ready,
	.int_allow, .mem, .mem_rdata, .acc, .index, .stack_pointer,
	.program_counter, .result_flags);

// ---- cpu_register_set_and_flags_tb.sv ----
// testbench: self-checking run of the cpu register set
`timescale 1ns/10ps
module cpu_register_set_and_flags_tb
	import rsf_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, op_ready, int_allow;
	logic        pready, pslverr, erv;
	logic [7:0]  paddr, mem_rdata, acc, result_flags;
	logic [31:0] pwdata, prdata, rdv;
	logic [15:0] index, stack_pointer, program_counter;
	rsf_op_t     op;
	rsf_mem_t    mem;
	logic [7:0]  ram [0:65535];
	int          fail_count, tests_run, cyc;

	rsf_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .op, .op_ready, .int_allow,
		.mem, .mem_rdata, .acc, .index, .stack_pointer, .program_counter,
		.result_flags);

	//==========================================================
	// clock, memory and timeout
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	// synchronous ram; idle data line toggles so stale bytes never match
	always @(posedge pclk) begin
		if (mem.rd) mem_rdata <= ram[mem.addr];
		else mem_rdata <= ~mem_rdata;
		if (mem.wr) ram[mem.addr] <= mem.wdata;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			summarize();
		end
	end

	//==========================================================
	// shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		// only the bench timeout ends this wait
		while (!pready) @(posedge pclk);
		rdv = prdata;
		erv = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// hold the op until taken, then wait out any stall
	task op_do(input rsf_opc_t c, input logic [15:0] d);
		op <= '{1'b1, c, d};
		@(posedge pclk);
		while (!op_ready) @(posedge pclk);
		op.valid <= 1'b0;
		@(posedge pclk);
		while (!op_ready) @(posedge pclk);
		// one more edge so the last ram write has landed
		@(posedge pclk);
	endtask
	task t_boot;
		while (!op_ready && cyc < 3000) @(posedge pclk);
		chk({index[15:8], stack_pointer}, 24'h0000FF);
		chk(program_counter, 16'h1234);
		chk(result_flags, FLG_RST);
	endtask

	//==========================================================
	// scenarios
	task t_alu;
		op_do(OP_LDA, 16'h007F);
		op_do(OP_ADD, 16'h0001);
		chk({acc, result_flags}, 16'h80FC);
		op_do(OP_ADD, 16'h0080);
		chk({acc, result_flags}, 16'h00EB);
		op_do(OP_ADC, 16'h0000);
		chk(acc, 8'h01);
		op_do(OP_SUB, 16'h0002);
		chk({acc, result_flags[2], result_flags[0]}, 10'h3FF);
		op_do(OP_LDA, 16'h0009);
		op_do(OP_ADD, 16'h0001);
		op_do(OP_DEC_ADJ, 16'h0000);
		chk(acc, 8'h10);
	endtask
	task t_index;
		rsf_opc_t   cd [9] = '{OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX,
			OP_LSLX, OP_LSRX, OP_ROLX, OP_RORX};
		logic [7:0] ex [9] = '{8'h00, 8'h82, 8'h80, 8'h7E, 8'h7F, 8'h02,
			8'h40, 8'h03, 8'hC0};
		for (int i = 0; i < 9; i++) begin
			op_do(OP_LDHX, 16'hA581);
			op_do(cd[i], 16'h0000);
			chk(index, {8'hA5, ex[i]});
			if (i > 4) chk(result_flags[0], 1'h1);
		end
	endtask
	task t_stack;
		op_do(OP_SP_ADJ, 16'h00FE);
		chk(stack_pointer, 16'h00FD);
		op_do(OP_SP_ADJ, 16'h0005);
		chk(stack_pointer, 16'h0102);
		op_do(OP_SP_LOW, 16'h0000);
		chk(stack_pointer[15:8], 8'h01);
		apb(1, OFS_SP, 32'h0140);
		op_do(OP_LDA, 16'h003C);
		op_do(OP_PUSH, 16'h0000);
		chk({ram[16'h0140], stack_pointer}, 24'h3C013F);
		op_do(OP_LDA, 16'h0000);
		op_do(OP_PULL, 16'h0000);
		chk({acc, stack_pointer}, 24'h3C0140);
	endtask
	task t_int;
		op_do(OP_MASK_CLR, 16'h0000);
		chk(int_allow, 1'h0);
		op_do(OP_JMP, 16'h1000);
		op_do(OP_FETCH, 16'h0000);
		chk(program_counter, 16'h1001);
		@(posedge pclk);
		chk(int_allow, 1'h1);
		apb(1, OFS_SP, 32'h0180);
		op_do(OP_INT, 16'h2000);
		chk({program_counter, stack_pointer}, 32'h2000017B);
		chk({ram[16'h0180], ram[16'h017F]}, 16'h0110);
		chk({ram[16'h017C][FB_I], result_flags[FB_I]}, 2'h1);
		chk(int_allow, 1'h0);
		op_do(OP_CALL, 16'h3000);
		chk({program_counter, stack_pointer}, 32'h30000179);
		chk({ram[16'h017B], ram[16'h017A]}, 16'h0020);
	endtask
	// store, bit test, flag transfer and signed branches
	task t_misc;
		op_do(OP_LDA, 16'h00C5);
		op_do(OP_STA, 16'h0200);
		chk({ram[16'h0200], result_flags[2:1]}, 10'h316);
		op_do(OP_BTST, 16'h0002);
		chk(result_flags[FB_C], 1'h1);
		op_do(OP_TAP, 16'h0000);
		chk({result_flags, int_allow}, 9'h1CA);
		op_do(OP_BR_LT, 16'h0010);
		chk({program_counter, int_allow}, 17'h06001);
		op_do(OP_BR_GE, 16'h00F0);
		chk(program_counter, 16'h2FF0);
		op_do(OP_SEI, 16'h0000);
		chk(int_allow, 1'h0);
		op_do(OP_LDX, 16'h0080);
		chk(result_flags[FB_N], 1'h1);
		apb(0, OFS_IDX, 32'h0);
		chk(rdv, 32'h0000A580);
		apb(0, OFS_PC, 32'h0);
		chk(rdv, 32'h00002FF0);
	endtask
	task t_apb;
		apb(1, OFS_FLG, 32'h0);
		apb(0, OFS_FLG, 32'h0);
		chk(rdv, 32'h60);
		apb(1, OFS_FLG, 32'hFF);
		apb(0, OFS_FLG, 32'h0);
		chk(rdv, 32'hFF);
		apb(0, 8'h20, 32'h0);
		chk({erv, rdv[30:0]}, 32'h80000000);
	endtask
	// acc and low index byte must survive a mid-run reset
	task t_rst2;
		op_do(OP_LDA, 16'h005A);
		op_do(OP_LDHX, 16'h77C3);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_boot();
		chk({acc, index}, 24'h5A00C3);
	endtask
	task summarize;
		$display("mismatches %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	//==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, mem_rdata} = '0;
		op = '0;
		ram[16'hFFFE] = 8'h12;
		ram[16'hFFFF] = 8'h34;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_boot();
		t_stack();
		t_alu();
		t_index();
		t_int();
		t_misc();
		t_apb();
		t_rst2();
		summarize();
	end
endmodule // cpu_register_set_and_flags_tb
